//--- dual_uart.sv
// What this block does
// - accept cycles only while device select low
// - pick low means channel B, high A
// - broadcast bit writes both channels at once
// - per-channel high interrupt while service needed
// - low transmit-ready reflects holding register fill
// - ir bit clear: standard async serial pins
// - standard transmit idles and resets high
// - ir bit set: ir coding, idle low
// - optional inversion of ir receive input
// - rts as automatic rs485 direction control
// - cts general input or gates transmitter
// - active low dtr general purpose output
// - rts general purpose output otherwise, deasserted while receive holding full if auto rts on
// - three-bit address picks channel register
// - read starts at strobe fall, data driven
// - write latched on write strobe rise
`timescale 1ns/1ps
`default_nettype none
module dual_uart (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       deviceSelectN,
  input  wire logic       channel_pick,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] busDataIn,
  output logic      [7:0] busDataOut,
  output logic            busDataOe,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  output logic            irq_out_a,
  output logic            irq_out_b,
  output logic            tx_space_n_a,
  output logic            tx_space_n_b,
  output logic            serial_out_a,
  output logic            serial_out_b,
  input  wire logic       serial_in_a,
  input  wire logic       serial_in_b,
  output logic            request_send_n_a,
  output logic            request_send_n_b,
  input  wire logic       clear_send_n_a,
  input  wire logic       clear_send_n_b,
  output logic            terminal_ready_n_a,
  output logic            terminal_ready_n_b
);

  // ************************************************************
  // channel decode
  // ************************************************************
  // index 0 is channel A (pick high), index 1 is channel B (pick low)
  function automatic logic chanHit(input logic pick, input int idx);
    chanHit = (pick == (idx == 0));
  endfunction

  logic                     rdPrev_reg;
  logic                     wrPrev_reg;
  dual_uart_pkg::host_cycle_s cap_reg;
  logic                     rdStart;
  logic                     wrCommit;
  logic                     bcast;
  logic                     rdPick_reg;
  logic                     rdPend_reg;
  logic [1:0]               wrHit;
  logic [1:0]               rdHit;
  logic [1:0]               serialIn;
  logic [1:0]               ctsN;
  logic [1:0]               irqOut;
  logic [1:0]               txSpaceN;
  logic [1:0]               serialOut;
  logic [1:0]               rtsN;
  logic [1:0]               dtrN;
  logic [1:0]               bcastBit;
  logic [7:0]               chanRead [2];

  assign serialIn = {serial_in_b, serial_in_a};
  assign ctsN     = {clear_send_n_b, clear_send_n_a};

  // ************************************************************
  // host strobes
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdPrev_reg <= 1'b1;
      wrPrev_reg <= 1'b1;
    end else begin
      rdPrev_reg <= read_strobe_n;
      wrPrev_reg <= write_strobe_n;
    end
  end

  // address and data captured while write strobe is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cap_reg <= '0;
    end else if (!write_strobe_n) begin
      cap_reg <= {~deviceSelectN, channel_pick, regAddr, busDataIn};
    end
  end

  assign rdStart  = rdPrev_reg && !read_strobe_n && !deviceSelectN;
  assign wrCommit = !wrPrev_reg && write_strobe_n && cap_reg.sel;
  assign bcast    = |bcastBit;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wrHit[i] = wrCommit && (bcast || chanHit(cap_reg.pick, i));
      rdHit[i] = rdStart && chanHit(channel_pick, i);
    end
  end

  // ************************************************************
  // read data path
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdPend_reg <= 1'b0;
      rdPick_reg <= 1'b0;
    end else begin
      rdPend_reg <= rdStart;
      rdPick_reg <= channel_pick;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busDataOut <= 8'h00;
    end else if (rdPend_reg) begin
      busDataOut <= rdPick_reg ? chanRead[0] : chanRead[1];
    end
  end

  assign busDataOe = !read_strobe_n && !deviceSelectN && !rdStart;

  // ************************************************************
  // channels
  // ************************************************************
  for (genvar c = 0; c < 2; c++) begin : g_chan
    dual_uart_pkg::chan_regs_s  regs_reg;
    dual_uart_pkg::line_state_e txState_reg;
    dual_uart_pkg::line_state_e rxState_reg;
    logic [7:0]  hold_reg;
    logic [7:0]  rhr_reg;
    logic [7:0]  txShift_reg;
    logic [7:0]  rxShift_reg;
    logic [15:0] txCnt_reg;
    logic [15:0] rxCnt_reg;
    logic [15:0] irCnt_reg;
    logic [2:0]  txBit_reg;
    logic [2:0]  rxBit_reg;
    logic        thrFull_reg;
    logic        rxFull_reg;
    logic        ctsPrev_reg;
    logic        ctsDelta_reg;
    logic        serialOut_reg;
    logic        rtsN_reg;
    logic        dtrN_reg;
    logic        irq_reg;
    logic        txSpaceN_reg;
    logic        wrData;
    logic        rdData;
    logic        rdStatus;
    logic        txLoad;
    logic        rxDone;
    logic        txLine;
    logic        irMode;
    logic        irRaw;
    logic        rxLine;
    logic        rxPend;
    logic        txPend;
    logic        ctsPend;

    assign wrData   = wrHit[c] && (cap_reg.addr == dual_uart_pkg::OFS_DATA);
    assign rdData   = rdHit[c] && (regAddr == dual_uart_pkg::OFS_DATA);
    assign rdStatus = rdPend_reg && chanHit(rdPick_reg, c) && regAddr == dual_uart_pkg::OFS_MSTAT;
    assign irMode   = regs_reg.mdm[dual_uart_pkg::MDM_IR];

    // register writes
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        regs_reg <= {6{dual_uart_pkg::REG_RST}};
        hold_reg <= dual_uart_pkg::REG_RST;
      end else if (wrHit[c]) begin
        case (cap_reg.addr)
          dual_uart_pkg::OFS_DATA:     hold_reg      <= cap_reg.data;
          dual_uart_pkg::OFS_IEN:      regs_reg.ien  <= cap_reg.data;
          dual_uart_pkg::OFS_PEND_ALT: regs_reg.alt  <= cap_reg.data;
          dual_uart_pkg::OFS_FEAT:     regs_reg.feat <= cap_reg.data;
          dual_uart_pkg::OFS_MDM:      regs_reg.mdm  <= cap_reg.data;
          dual_uart_pkg::OFS_MSTAT:    regs_reg.xst  <= cap_reg.data;
          dual_uart_pkg::OFS_ENH:      regs_reg.enh  <= cap_reg.data;
          default:                     hold_reg      <= hold_reg;
        endcase
      end
    end

    assign bcastBit[c] = regs_reg.alt[dual_uart_pkg::ALT_BCAST];

    // holding register fill, set wins over clear
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        thrFull_reg <= 1'b0;
        rxFull_reg  <= 1'b0;
      end else begin
        thrFull_reg <= wrData || (thrFull_reg && !txLoad);
        rxFull_reg  <= rxDone || (rxFull_reg && !rdData);
      end
    end

    // cts change flag, cleared by status read
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        ctsPrev_reg  <= ctsN[c];
        ctsDelta_reg <= 1'b0;
      end else begin
        ctsPrev_reg  <= ctsN[c];
        ctsDelta_reg <= (ctsPrev_reg != ctsN[c]) || (ctsDelta_reg && !rdStatus);
      end
    end

    // transmitter, held off by cts when auto cts is on
    assign txLoad = (txState_reg == dual_uart_pkg::LN_IDLE) && thrFull_reg &&
                    !(regs_reg.enh[dual_uart_pkg::ENH_AUTO_CTS] && ctsN[c]);

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        txState_reg <= dual_uart_pkg::LN_IDLE;
        txCnt_reg   <= 16'h0000;
        txBit_reg   <= 3'h0;
        txShift_reg <= 8'h00;
      end else begin
        case (txState_reg)
          dual_uart_pkg::LN_IDLE: begin
            txCnt_reg <= 16'h0000;
            if (txLoad) begin
              txShift_reg <= hold_reg;
              txState_reg <= dual_uart_pkg::LN_START;
            end
          end
          dual_uart_pkg::LN_START: begin
            txCnt_reg <= txCnt_reg + 16'h0001;
            if (txCnt_reg == dual_uart_pkg::BIT_CYCLES - 16'h0001) begin
              txCnt_reg   <= 16'h0000;
              txBit_reg   <= 3'h0;
              txState_reg <= dual_uart_pkg::LN_DATA;
            end
          end
          dual_uart_pkg::LN_DATA: begin
            txCnt_reg <= txCnt_reg + 16'h0001;
            if (txCnt_reg == dual_uart_pkg::BIT_CYCLES - 16'h0001) begin
              txCnt_reg   <= 16'h0000;
              txShift_reg <= {1'b0, txShift_reg[7:1]};
              txBit_reg   <= txBit_reg + 3'h1;
              if (txBit_reg == dual_uart_pkg::LAST_BIT) begin
                txState_reg <= dual_uart_pkg::LN_STOP;
              end
            end
          end
          dual_uart_pkg::LN_STOP: begin
            txCnt_reg <= txCnt_reg + 16'h0001;
            if (txCnt_reg == dual_uart_pkg::BIT_CYCLES - 16'h0001) begin
              txCnt_reg   <= 16'h0000;
              txState_reg <= dual_uart_pkg::LN_IDLE;
            end
          end
          default: txState_reg <= dual_uart_pkg::LN_IDLE;
        endcase
      end
    end

    always_comb begin
      case (txState_reg)
        dual_uart_pkg::LN_START: txLine = 1'b0;
        dual_uart_pkg::LN_DATA:  txLine = txShift_reg[0];
        default:                 txLine = 1'b1;
      endcase
    end

    // serial output, ir pulse on each zero bit
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        serialOut_reg <= 1'b1;
      end else if (irMode) begin
        serialOut_reg <= !txLine && (txCnt_reg < dual_uart_pkg::IR_PULSE);
      end else begin
        serialOut_reg <= txLine;
      end
    end

    // ir decoder: pulse stretched to one bit time
    assign irRaw = regs_reg.feat[dual_uart_pkg::FEAT_IR_INV] ? !serialIn[c] : serialIn[c];

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        irCnt_reg <= 16'h0000;
      end else if (irMode && irRaw) begin
        irCnt_reg <= dual_uart_pkg::BIT_CYCLES;
      end else if (irCnt_reg != 16'h0000) begin
        irCnt_reg <= irCnt_reg - 16'h0001;
      end
    end

    assign rxLine = irMode ? (irCnt_reg == 16'h0000) : serialIn[c];

    // receiver
    assign rxDone = (rxState_reg == dual_uart_pkg::LN_STOP) &&
                    (rxCnt_reg == dual_uart_pkg::BIT_CYCLES - 16'h0001);

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        rxState_reg <= dual_uart_pkg::LN_IDLE;
        rxCnt_reg   <= 16'h0000;
        rxBit_reg   <= 3'h0;
        rxShift_reg <= 8'h00;
        rhr_reg     <= 8'h00;
      end else begin
        case (rxState_reg)
          dual_uart_pkg::LN_IDLE: begin
            rxCnt_reg <= 16'h0000;
            if (!rxLine) begin
              rxState_reg <= dual_uart_pkg::LN_START;
            end
          end
          dual_uart_pkg::LN_START: begin
            rxCnt_reg <= rxCnt_reg + 16'h0001;
            if (rxCnt_reg == dual_uart_pkg::HALF_BIT) begin
              rxCnt_reg   <= 16'h0000;
              rxBit_reg   <= 3'h0;
              rxState_reg <= rxLine ? dual_uart_pkg::LN_IDLE : dual_uart_pkg::LN_DATA;
            end
          end
          dual_uart_pkg::LN_DATA: begin
            rxCnt_reg <= rxCnt_reg + 16'h0001;
            if (rxCnt_reg == dual_uart_pkg::BIT_CYCLES - 16'h0001) begin
              rxCnt_reg   <= 16'h0000;
              rxShift_reg <= {rxLine, rxShift_reg[7:1]};
              rxBit_reg   <= rxBit_reg + 3'h1;
              if (rxBit_reg == dual_uart_pkg::LAST_BIT) begin
                rxState_reg <= dual_uart_pkg::LN_STOP;
              end
            end
          end
          dual_uart_pkg::LN_STOP: begin
            rxCnt_reg <= rxCnt_reg + 16'h0001;
            if (rxDone) begin
              rxCnt_reg   <= 16'h0000;
              rhr_reg     <= rxShift_reg;
              rxState_reg <= dual_uart_pkg::LN_IDLE;
            end
          end
          default: rxState_reg <= dual_uart_pkg::LN_IDLE;
        endcase
      end
    end

    // interrupt sources
    assign rxPend  = regs_reg.ien[dual_uart_pkg::IEN_RX] && rxFull_reg;
    assign txPend  = regs_reg.ien[dual_uart_pkg::IEN_TX] && !thrFull_reg;
    assign ctsPend = regs_reg.ien[dual_uart_pkg::IEN_CTS] && ctsDelta_reg;

    // modem and status outputs
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        irq_reg      <= 1'b0;
        txSpaceN_reg <= 1'b0;
        dtrN_reg     <= 1'b1;
        rtsN_reg     <= 1'b1;
      end else begin
        irq_reg      <= rxPend || txPend || ctsPend;
        txSpaceN_reg <= thrFull_reg;
        dtrN_reg     <= !regs_reg.mdm[dual_uart_pkg::MDM_DTR];
        if (regs_reg.feat[dual_uart_pkg::FEAT_RS485]) begin
          rtsN_reg <= (txState_reg == dual_uart_pkg::LN_IDLE) ^
                      regs_reg.xst[dual_uart_pkg::XST_RS485_INV];
        end else if (regs_reg.enh[dual_uart_pkg::ENH_AUTO_RTS]) begin
          rtsN_reg <= !(regs_reg.mdm[dual_uart_pkg::MDM_RTS] && !rxFull_reg);
        end else begin
          rtsN_reg <= !regs_reg.mdm[dual_uart_pkg::MDM_RTS];
        end
      end
    end

    // read mux
    always_comb begin
      case (regAddr)
        dual_uart_pkg::OFS_DATA:     chanRead[c] = rhr_reg;
        dual_uart_pkg::OFS_IEN:      chanRead[c] = regs_reg.ien;
        dual_uart_pkg::OFS_PEND_ALT: chanRead[c] = {5'h00, ctsPend, txPend, rxPend};
        dual_uart_pkg::OFS_FEAT:     chanRead[c] = regs_reg.feat;
        dual_uart_pkg::OFS_MDM:      chanRead[c] = regs_reg.mdm;
        dual_uart_pkg::OFS_LSR:      chanRead[c] = {1'b0,
                                                    (txState_reg == dual_uart_pkg::LN_IDLE) &&
                                                    !thrFull_reg,
                                                    !thrFull_reg, 4'h0, rxFull_reg};
        dual_uart_pkg::OFS_MSTAT:    chanRead[c] = {ctsDelta_reg, 2'h0, !ctsN[c],
                                                    regs_reg.xst[3:0]};
        dual_uart_pkg::OFS_ENH:      chanRead[c] = regs_reg.enh;
        default:                     chanRead[c] = 8'h00;
      endcase
    end

    assign irqOut[c]    = irq_reg;
    assign txSpaceN[c]  = txSpaceN_reg;
    assign serialOut[c] = serialOut_reg;
    assign rtsN[c]      = rtsN_reg;
    assign dtrN[c]      = dtrN_reg;
  end

  // ************************************************************
  // pin mapping
  // ************************************************************
  assign irq_out_a          = irqOut[0];
  assign irq_out_b          = irqOut[1];
  assign tx_space_n_a       = txSpaceN[0];
  assign tx_space_n_b       = txSpaceN[1];
  assign serial_out_a       = serialOut[0];
  assign serial_out_b       = serialOut[1];
  assign request_send_n_a   = rtsN[0];
  assign request_send_n_b   = rtsN[1];
  assign terminal_ready_n_a = dtrN[0];
  assign terminal_ready_n_b = dtrN[1];

endmodule
`default_nettype wire

//--- dual_uart_pkg.sv
`default_nettype none
package dual_uart_pkg;

  // ************************************************************
  // bus widths and register offsets
  // ************************************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFS_DATA     = 3'h0;
  localparam logic [2:0] OFS_IEN      = 3'h1;
  localparam logic [2:0] OFS_PEND_ALT = 3'h2;
  localparam logic [2:0] OFS_FEAT     = 3'h3;
  localparam logic [2:0] OFS_MDM      = 3'h4;
  localparam logic [2:0] OFS_LSR      = 3'h5;
  localparam logic [2:0] OFS_MSTAT    = 3'h6;
  localparam logic [2:0] OFS_ENH      = 3'h7;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int MDM_DTR        = 0;
  localparam int MDM_RTS        = 1;
  localparam int MDM_IR         = 6;
  localparam int FEAT_IR_INV    = 2;
  localparam int FEAT_RS485     = 3;
  localparam int XST_RS485_INV  = 3;
  localparam int ENH_AUTO_RTS   = 6;
  localparam int ENH_AUTO_CTS   = 7;
  localparam int IEN_RX         = 0;
  localparam int IEN_TX         = 1;
  localparam int IEN_CTS        = 7;
  localparam int ALT_BCAST      = 0;
  localparam logic [7:0] REG_RST = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ  = 50000000;
  localparam int BAUD_HZ = 115200;
  localparam logic [15:0] BIT_CYCLES  = 16'(CLK_HZ / BAUD_HZ);
  localparam logic [15:0] HALF_BIT    = 16'(CLK_HZ / BAUD_HZ / 2);
  localparam logic [15:0] IR_PULSE    = 16'(CLK_HZ / BAUD_HZ * 3 / 16);
  localparam logic [2:0]  LAST_BIT    = 3'h7;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    LN_IDLE  = 2'b00,
    LN_START = 2'b01,
    LN_DATA  = 2'b10,
    LN_STOP  = 2'b11
  } line_state_e;

  typedef struct packed {
    logic [7:0] ien;
    logic [7:0] alt;
    logic [7:0] feat;
    logic [7:0] mdm;
    logic [7:0] xst;
    logic [7:0] enh;
  } chan_regs_s;

  typedef struct packed {
    logic       sel;
    logic       pick;
    logic [2:0] addr;
    logic [7:0] data;
  } host_cycle_s;

endpackage
`default_nettype wire

//--- dual_uart_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dual_uart_asserts (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       deviceSelectN,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic [7:0] busDataOut,
  input wire logic       busDataOe,
  input wire logic       irq_out_a,
  input wire logic       irq_out_b,
  input wire logic       tx_space_n_a,
  input wire logic       tx_space_n_b,
  input wire logic       serial_out_a,
  input wire logic       serial_out_b,
  input wire logic       request_send_n_a,
  input wire logic       request_send_n_b,
  input wire logic       terminal_ready_n_a,
  input wire logic       terminal_ready_n_b
);
  // ************************************************************
  // strobe history
  // ************************************************************
  logic [2:0] wrHist;
  logic [1:0] rdHist;
  always_ff @(posedge clk) begin
    wrHist <= {wrHist[1:0], write_strobe_n};
    rdHist <= {rdHist[0], read_strobe_n};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ************************************************************
  // properties
  // ************************************************************
  AST_RESET_A: assert property ($fell(sys_rst) |-> serial_out_a && request_send_n_a
    && terminal_ready_n_a && !irq_out_a && !tx_space_n_a) else $error("channel a reset levels");
  AST_RESET_B: assert property ($fell(sys_rst) |-> serial_out_b && request_send_n_b
    && terminal_ready_n_b && !irq_out_b && !tx_space_n_b) else $error("channel b reset levels");
  AST_OE_SELECT: assert property ((deviceSelectN || read_strobe_n) |-> !busDataOe)
    else $error("bus driven without read");
  AST_OE_READ: assert property (!deviceSelectN && !read_strobe_n && !rdHist[0] |-> busDataOe)
    else $error("bus not driven during read");
  AST_DOUT_CAUSE: assert property ($changed(busDataOut) |-> rdHist != 2'h3)
    else $error("read data changed without read");
  AST_DTR_CAUSE_A: assert property ($changed(terminal_ready_n_a) |-> wrHist != 3'h7)
    else $error("dtr a changed without write");
  AST_DTR_CAUSE_B: assert property ($changed(terminal_ready_n_b) |-> wrHist != 3'h7)
    else $error("dtr b changed without write");
  AST_TXSPACE_A: assert property ($rose(tx_space_n_a) |-> wrHist != 3'h7)
    else $error("tx space a fell without load");
  AST_TXSPACE_B: assert property ($rose(tx_space_n_b) |-> wrHist != 3'h7)
    else $error("tx space b fell without load");
  cover property ($rose(busDataOe));
  cover property ($rose(tx_space_n_a));
  cover property ($rose(irq_out_b));
endmodule
bind dual_uart dual_uart_asserts u_dual_uart_asserts (.clk, .sys_rst, .deviceSelectN,
  .read_strobe_n, .write_strobe_n, .busDataOut, .busDataOe, .irq_out_a, .irq_out_b,
  .tx_space_n_a, .tx_space_n_b, .serial_out_a, .serial_out_b, .request_send_n_a,
  .request_send_n_b, .terminal_ready_n_a, .terminal_ready_n_b);
`default_nettype wire

//--- serial_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
  input  wire logic clk,
  output logic      lineOut,
  output logic      ctsN
);
  // ************************************************************
  // idle line, cts granted, 8n1 frames
  // ************************************************************
  initial begin
    lineOut = 1'b1;
    ctsN = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] frm;
    frm = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      lineOut <= frm[i];
      repeat (dual_uart_pkg::BIT_CYCLES - 16'h0001) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- dual_uart_host_select_and_serial_pins_test.sv
`timescale 1ns/1ps
`default_nettype none
module dual_uart_host_select_and_serial_pins_test;
  // ************************************************************
  // pins and model
  // ************************************************************
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       deviceSelectN = 1'b1;
  logic       channel_pick = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] busDataIn = 8'h00;
  logic       read_strobe_n = 1'b1;
  logic       write_strobe_n = 1'b1;
  logic [7:0] busDataOut;
  logic       busDataOe, irq_out_a, irq_out_b, tx_space_n_a, tx_space_n_b;
  logic       serial_out_a, serial_out_b, request_send_n_a, request_send_n_b;
  logic       terminal_ready_n_a, terminal_ready_n_b;
  logic       serial_in_a, serial_in_b, clear_send_n_a, clear_send_n_b;
  int         failures = 0;
  int         n_checks = 0;
  logic [7:0] mdl [2][8];
  logic [7:0] got, x0, x1;
  logic [2:0] ofs [3] = '{dual_uart_pkg::OFS_IEN, dual_uart_pkg::OFS_FEAT, dual_uart_pkg::OFS_MDM};
  always #10 clk = ~clk;
  dual_uart u_dual_uart (.clk, .sys_rst, .deviceSelectN, .channel_pick, .regAddr, .busDataIn,
    .busDataOut, .busDataOe, .read_strobe_n, .write_strobe_n, .irq_out_a, .irq_out_b,
    .tx_space_n_a, .tx_space_n_b, .serial_out_a, .serial_out_b, .serial_in_a, .serial_in_b,
    .request_send_n_a, .request_send_n_b, .clear_send_n_a, .clear_send_n_b,
    .terminal_ready_n_a, .terminal_ready_n_b);
  serial_line_model u_line_a (.clk(clk), .lineOut(serial_in_a), .ctsN(clear_send_n_a));
  serial_line_model u_line_b (.clk(clk), .lineOut(serial_in_b), .ctsN(clear_send_n_b));
  // ************************************************************
  // compares and bus cycles
  // ************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pin(input string what, input logic exp, input logic seen);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic wr(input logic pk, input logic [2:0] a, input logic [7:0] d, input logic selN);
    logic bc;
    bc = mdl[0][2][0] | mdl[1][2][0];
    @(posedge clk);
    deviceSelectN <= selN;
    channel_pick <= pk;
    regAddr <= a;
    busDataIn <= d;
    write_strobe_n <= 1'b0;
    @(posedge clk);
    write_strobe_n <= 1'b1;
    @(posedge clk);
    deviceSelectN <= 1'b1;
    repeat (2) @(posedge clk);
    for (int c = 0; c < 2; c++) if (!selN && (bc || c == (pk ? 0 : 1))) mdl[c][a] = d;
  endtask
  task automatic rd(input logic pk, input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    deviceSelectN <= 1'b0;
    channel_pick <= pk;
    regAddr <= a;
    read_strobe_n <= 1'b0;
    repeat (3) @(posedge clk);
    d = busDataOut;
    pin("read enable", 1'b1, busDataOe);
    read_strobe_n <= 1'b1;
    deviceSelectN <= 1'b1;
  endtask
  task automatic rchk(input logic pk, input logic [2:0] a);
    rd(pk, a, got);
    chk("register", mdl[pk ? 0 : 1][a], got);
  endtask
  task automatic grab(output logic [7:0] b);
    int w;
    w = 0;
    while (serial_out_a === 1'b1 && w < 6000) begin
      @(posedge clk);
      w++;
    end
    repeat (dual_uart_pkg::HALF_BIT) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (dual_uart_pkg::BIT_CYCLES) @(posedge clk);
      if (i < 8) b[i] = serial_out_a;
    end
    pin("stop bit", 1'b1, serial_out_a);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h4888));
    for (int c = 0; c < 16; c++) mdl[c / 8][c % 8] = dual_uart_pkg::REG_RST;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    pin("serial out a", 1'b1, serial_out_a);
    pin("serial out b", 1'b1, serial_out_b);
    pin("dtr a", 1'b1, terminal_ready_n_a);
    pin("rts b", 1'b1, request_send_n_b);
    pin("tx space a", 1'b0, tx_space_n_a);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      wr(1'b1, ofs[i], 8'($urandom) & 8'hBF, 1'b0);
      wr(1'b0, ofs[i], 8'($urandom) & 8'hBF, 1'b0);
      wr(1'($urandom), ofs[i], 8'($urandom), 1'b1);
      rchk(1'b1, ofs[i]);
      rchk(1'b0, ofs[i]);
    end
    $display("test routing done");
    wr(1'b1, dual_uart_pkg::OFS_FEAT, 8'h00, 1'b0);
    wr(1'b0, dual_uart_pkg::OFS_FEAT, 8'h00, 1'b0);
    wr(1'b1, dual_uart_pkg::OFS_MDM, 8'h03, 1'b0);
    wr(1'b0, dual_uart_pkg::OFS_MDM, 8'h01, 1'b0);
    pin("dtr a", 1'b0, terminal_ready_n_a);
    pin("rts a", 1'b0, request_send_n_a);
    pin("dtr b", 1'b0, terminal_ready_n_b);
    pin("rts b", 1'b1, request_send_n_b);
    wr(1'b1, dual_uart_pkg::OFS_MDM, 8'h40, 1'b0);
    pin("ir idle a", 1'b0, serial_out_a);
    pin("idle b", 1'b1, serial_out_b);
    wr(1'b1, dual_uart_pkg::OFS_MDM, 8'h00, 1'b0);
    pin("idle a", 1'b1, serial_out_a);
    $display("test pins done");
    wr(1'b1, dual_uart_pkg::OFS_PEND_ALT, 8'h01, 1'b0);
    wr(1'b0, dual_uart_pkg::OFS_IEN, 8'($urandom), 1'b0);
    rchk(1'b1, dual_uart_pkg::OFS_IEN);
    rchk(1'b0, dual_uart_pkg::OFS_IEN);
    wr(1'b1, dual_uart_pkg::OFS_PEND_ALT, 8'h00, 1'b0);
    wr(1'b0, dual_uart_pkg::OFS_IEN, 8'h00, 1'b0);
    wr(1'b1, dual_uart_pkg::OFS_IEN, 8'h02, 1'b0);
    pin("irq a", 1'b1, irq_out_a);
    pin("irq b", 1'b0, irq_out_b);
    wr(1'b1, dual_uart_pkg::OFS_IEN, 8'h00, 1'b0);
    pin("irq a", 1'b0, irq_out_a);
    $display("test broadcast and interrupt done");
    x0 = 8'($urandom);
    wr(1'b0, dual_uart_pkg::OFS_IEN, 8'h01, 1'b0);
    u_line_b.send(x0);
    repeat (4) @(posedge clk);
    pin("irq b", 1'b1, irq_out_b);
    pin("irq a", 1'b0, irq_out_a);
    rd(1'b0, dual_uart_pkg::OFS_DATA, got);
    chk("received byte", x0, got);
    repeat (3) @(posedge clk);
    pin("irq b", 1'b0, irq_out_b);
    $display("test receive done");
    x0 = 8'($urandom);
    x1 = 8'($urandom);
    wr(1'b1, dual_uart_pkg::OFS_FEAT, 8'h08, 1'b0);
    wr(1'b1, dual_uart_pkg::OFS_DATA, x0, 1'b0);
    wr(1'b1, dual_uart_pkg::OFS_DATA, x1, 1'b0);
    pin("tx space a", 1'b1, tx_space_n_a);
    pin("tx space b", 1'b0, tx_space_n_b);
    pin("rts a", 1'b0, request_send_n_a);
    grab(got);
    chk("sent byte", x0, got);
    grab(got);
    chk("sent byte", x1, got);
    pin("tx space a", 1'b0, tx_space_n_a);
    $display("test transmit done");
    wrap_up();
  end
endmodule
`default_nettype wire
